// ===== rtl/dcsr_pkg.sv
// Package of offsets, field positions and reset values for the status bank.
`default_nettype none
package dcsr_pkg;
	// Printed offsets are not all multiples of four, so they are indices.
	localparam logic [5:0] IDX_STATUS   = 6'h00;
	localparam logic [5:0] IDX_ERRORS   = 6'h01;
	localparam logic [5:0] IDX_HBC      = 6'h0F;
	localparam logic [5:0] IDX_SECTOR   = 6'h12;
	localparam logic [5:0] IDX_NSO      = 6'h13;
	localparam logic [5:0] IDX_DIAG     = 6'h36;
	localparam logic [5:0] IDX_CONTROL  = 6'h20;
	localparam logic [5:0] IDX_FORMAT   = 6'h21;
	localparam int unsigned ADDR_LSB    = 2;
	localparam int unsigned ADDR_W      = 8;
	// Control register fields.
	localparam int unsigned CTL_STANDBY   = 0;
	localparam int unsigned CTL_INTERLOCK = 1;
	localparam int unsigned CTL_HARD_SEC  = 2;
	// Format register fields.
	localparam int unsigned FMT_HDR_LO  = 0;
	localparam int unsigned FMT_DAT_LO  = 2;
	// Status bit positions.
	localparam int unsigned ST_HDR_FAULT  = 0;
	localparam int unsigned ST_NEXT_CMD   = 1;
	localparam int unsigned ST_HDR_MATCH  = 2;
	localparam int unsigned ST_LOCAL_REQ  = 3;
	localparam int unsigned ST_REMOTE_ACT = 4;
	localparam int unsigned ST_LOCAL_ACT  = 5;
	localparam int unsigned ST_FIXUP_ACT  = 6;
	localparam int unsigned ST_ANY_ERROR  = 7;
	// Error bit positions.
	localparam int unsigned ER_PARTIAL  = 0;
	localparam int unsigned ER_DATA     = 1;
	localparam int unsigned ER_MISSING  = 2;
	localparam int unsigned ER_OVERRUN  = 3;
	localparam int unsigned ER_SYNC     = 4;
	localparam int unsigned ER_FIFO     = 5;
	localparam int unsigned ER_FIXUP    = 6;
	localparam int unsigned ER_LATE     = 7;
	// Check appendage codes.
	localparam logic [1:0] CHK_NONE  = 2'h0;
	localparam logic [1:0] CHK_CRC16 = 2'h1;
	localparam logic [1:0] CHK_ECC32 = 2'h2;
	localparam logic [1:0] CHK_ECC48 = 2'h3;
	// Reset values, bus response codes and the index-pulse count limit.
	localparam logic [7:0] RST_STATUS  = 8'h02;
	localparam logic [3:0] RST_HBC     = 4'h6;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] IDX_COUNT_DONE = 2'h2;
	typedef enum logic [1:0] {
		DCSR_HDR_IGNORE,
		DCSR_HDR_WRITE,
		DCSR_HDR_COMPARE,
		DCSR_HDR_READ
	} dcsr_hdr_mode_t;
endpackage
`default_nettype wire

// ===== rtl/dcsr_regs.sv
// Status, error and multi-sector register bank behind an AXI4-Lite slave.
// Operation
// - Two-bit check appendage codes for header, data
// - Header fault sets on check error, clears
// - Read-header check error aborts, no error bits
// - Next-command flag set when ready, cleared on command
// - Header-matched flag set per mode, cleared data end
// - Status D3 mirrors local DMA request output
// - D4 remote busy, D5 local busy
// - Fixup active from start to end of cycle
// - D7 is OR of all error flags
// - Reset and standby bit clear status, errors
// - Partial header mismatch sets, aborts command
// - Data check error after match sets D1
// - Two index pulses without match: sector missing
// - Pulse during transfer: overrun, abort, drop gates
// - Index, or sector pulse when hard-sectored, during sync hunt
// - FIFO overflow or underrun sets lost flag
// - Fixup end at zero unlocated sets failed
// - Late interlock when count register not written
// - Sector counter substitutes, increments per header
// - Ops counter decrements, ends command at zero
// - Header count write strobes interlock update
`default_nettype none
module dcsr_regs (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        new_command_i,
	input  wire logic [1:0]  header_mode_i,
	input  wire logic        header_done_i,
	input  wire logic        header_check_err_i,
	input  wire logic        header_match_i,
	input  wire logic        partial_match_i,
	input  wire logic        data_check_err_i,
	input  wire logic        data_op_done_i,
	input  wire logic        transfer_active_i,
	input  wire logic        sync_hunt_i,
	input  wire logic        sync_lost_i,
	input  wire logic        fifo_overflow_i,
	input  wire logic        fifo_underrun_i,
	input  wire logic        local_dma_request_i,
	input  wire logic        remote_dma_active_i,
	input  wire logic        local_dma_active_i,
	input  wire logic        fixup_start_i,
	input  wire logic        fixup_end_i,
	input  wire logic        fixup_located_i,
	input  wire logic        byte_count_zero_i,
	input  wire logic        next_header_i,
	input  wire logic [7:0]  fifo_byte_i,
	input  wire logic        index_pulse_i,
	input  wire logic        sector_pulse_i,
	output logic             abort_o,
	output logic             command_done_o,
	output logic             read_gate_out_o,
	output logic             write_gate_out_o,
	output logic [1:0]       header_check_sel_o,
	output logic [1:0]       data_check_sel_o,
	output logic [7:0]       sector_subst_o,
	output logic             interlock_strobe_o,
	output logic             ext_header_ecc_o,
	output logic             standby_o
);

	typedef struct packed {
		logic [2:0] idx_sync;
		logic [2:0] sec_sync;
		logic [7:0] status;
		logic [7:0] errors;
		logic [3:0] header_count_interlock;
		logic [7:0] sector;
		logic [7:0] sector_ops_remaining;
		logic [2:0] control;
		logic [3:0] format;
		logic       hbc_written;
		logic [1:0] idx_count;
		logic       abort;
		logic       done;
		logic       strobe;
		logic       aw_held;
		logic [5:0] aw_idx;
		logic       w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dcsr_state_t;

	dcsr_state_t st;
	dcsr_state_t next_st;

	logic idx_rise;
	logic sec_rise;
	logic wr_go;
	logic rd_go;
	logic clear_all;
	logic pulse_hit;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic [5:0] ar_idx;

	// Bits 0 of the sync chains are first stages; only bit 1 and 2 are read.
	assign idx_rise = st.idx_sync[1] & ~st.idx_sync[2];
	assign sec_rise = st.sec_sync[1] & ~st.sec_sync[2];
	assign ar_idx = s_axi_araddr[dcsr_pkg::ADDR_LSB +: 6];
	assign wr_go = st.aw_held & st.w_held & ~st.bvalid;
	assign rd_go = s_axi_arvalid & ~st.rvalid;
	assign clear_all = st.control[dcsr_pkg::CTL_STANDBY];

	always_comb begin
		rd_ok = 1'b1;
		rd_byte = dcsr_pkg::RST_BYTE;
		unique case (ar_idx)
			dcsr_pkg::IDX_STATUS:  rd_byte = st.status;
			dcsr_pkg::IDX_ERRORS:  rd_byte = st.errors;
			dcsr_pkg::IDX_HBC:     rd_byte = {5'h00, st.header_count_interlock[2:0]};
			dcsr_pkg::IDX_SECTOR:  rd_byte = st.sector;
			dcsr_pkg::IDX_NSO:     rd_byte = st.sector_ops_remaining;
			dcsr_pkg::IDX_DIAG:    rd_byte = fifo_byte_i;
			dcsr_pkg::IDX_CONTROL: rd_byte = {5'h00, st.control};
			dcsr_pkg::IDX_FORMAT:  rd_byte = {4'h0, st.format};
			default:               rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.idx_sync = {st.idx_sync[1:0], index_pulse_i};
		next_st.sec_sync = {st.sec_sync[1:0], sector_pulse_i};
		next_st.abort = 1'b0;
		next_st.done = 1'b0;
		next_st.strobe = 1'b0;
		pulse_hit = idx_rise |
			(sec_rise & st.control[dcsr_pkg::CTL_HARD_SEC]);

		// Bus handshakes: address and data may come in either order.
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_idx = s_axi_awaddr[dcsr_pkg::ADDR_LSB +: 6];
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h000000, rd_byte};
			next_st.rresp = rd_ok ? dcsr_pkg::RESP_OKAY
				: dcsr_pkg::RESP_SLVERR;
		end

		// Hardware event flags; a new command clears before events apply.
		if (new_command_i) begin
			next_st.errors = 8'h00;
			next_st.status[dcsr_pkg::ST_HDR_FAULT] = 1'b0;
			next_st.status[dcsr_pkg::ST_NEXT_CMD] = 1'b0;
			next_st.idx_count = 2'h0;
		end
		if (data_op_done_i) begin
			next_st.status[dcsr_pkg::ST_HDR_MATCH] = 1'b0;
			next_st.status[dcsr_pkg::ST_NEXT_CMD] = 1'b1;
		end
		if (header_check_err_i) begin
			next_st.status[dcsr_pkg::ST_HDR_FAULT] = 1'b1;
			if (header_mode_i == 2'(dcsr_pkg::DCSR_HDR_READ)) begin
				next_st.abort = 1'b1;
			end
		end
		if (header_match_i) begin
			next_st.status[dcsr_pkg::ST_HDR_FAULT] = 1'b0;
			next_st.status[dcsr_pkg::ST_HDR_MATCH] = 1'b1;
			next_st.idx_count = 2'h0;
		end
		if (header_done_i &&
			(header_mode_i != 2'(dcsr_pkg::DCSR_HDR_COMPARE))) begin
			next_st.status[dcsr_pkg::ST_HDR_MATCH] = 1'b1;
		end
		if (partial_match_i &&
			header_mode_i == 2'(dcsr_pkg::DCSR_HDR_COMPARE)) begin
			next_st.errors[dcsr_pkg::ER_PARTIAL] = 1'b1;
			next_st.abort = 1'b1;
		end
		if (data_check_err_i) begin
			next_st.errors[dcsr_pkg::ER_DATA] = 1'b1;
		end
		if (idx_rise && !st.status[dcsr_pkg::ST_HDR_MATCH] &&
			header_mode_i == 2'(dcsr_pkg::DCSR_HDR_COMPARE)) begin
			next_st.idx_count = st.idx_count + 2'h1;
			if (st.idx_count == dcsr_pkg::IDX_COUNT_DONE - 2'h1) begin
				next_st.errors[dcsr_pkg::ER_MISSING] = 1'b1;
				next_st.abort = 1'b1;
			end
		end
		if (transfer_active_i && (idx_rise || sec_rise)) begin
			next_st.errors[dcsr_pkg::ER_OVERRUN] = 1'b1;
			next_st.abort = 1'b1;
		end
		if ((sync_hunt_i && pulse_hit) || sync_lost_i) begin
			next_st.errors[dcsr_pkg::ER_SYNC] = 1'b1;
		end
		if (fifo_overflow_i || fifo_underrun_i) begin
			next_st.errors[dcsr_pkg::ER_FIFO] = 1'b1;
			next_st.abort = 1'b1;
		end
		if (fixup_start_i) begin
			next_st.status[dcsr_pkg::ST_FIXUP_ACT] = 1'b1;
		end
		if (fixup_end_i) begin
			next_st.status[dcsr_pkg::ST_FIXUP_ACT] = 1'b0;
			if (byte_count_zero_i && !fixup_located_i) begin
				next_st.errors[dcsr_pkg::ER_FIXUP] = 1'b1;
			end
		end
		if (next_header_i && st.control[dcsr_pkg::CTL_INTERLOCK]) begin
			if (!st.hbc_written) begin
				next_st.errors[dcsr_pkg::ER_LATE] = 1'b1;
			end
			next_st.hbc_written = 1'b0;
		end
		if (header_done_i) begin
			next_st.sector = st.sector + 8'h01;
			if (st.sector_ops_remaining != 8'h00) begin
				next_st.sector_ops_remaining = st.sector_ops_remaining - 8'h01;
				next_st.done = (st.sector_ops_remaining == 8'h01);
			end
		end

		// Register writes; a write to the count register also strobes.
		if (wr_go) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = dcsr_pkg::RESP_OKAY;
			if (st.w_strb[0]) begin
				unique case (st.aw_idx)
					dcsr_pkg::IDX_HBC: begin
						next_st.header_count_interlock = st.w_data[3:0];
						next_st.hbc_written = 1'b1;
						next_st.strobe = 1'b1;
					end
					dcsr_pkg::IDX_SECTOR: next_st.sector = st.w_data[7:0];
					dcsr_pkg::IDX_NSO: next_st.sector_ops_remaining = st.w_data[7:0];
					dcsr_pkg::IDX_CONTROL:
						next_st.control = st.w_data[2:0];
					dcsr_pkg::IDX_FORMAT: next_st.format = st.w_data[3:0];
					dcsr_pkg::IDX_STATUS, dcsr_pkg::IDX_ERRORS,
					dcsr_pkg::IDX_DIAG: next_st.bresp = dcsr_pkg::RESP_SLVERR;
					default: next_st.bresp = dcsr_pkg::RESP_SLVERR;
				endcase
			end
		end

		// Live mirrors and the summary bit are refreshed every cycle.
		next_st.status[dcsr_pkg::ST_LOCAL_REQ] = local_dma_request_i;
		next_st.status[dcsr_pkg::ST_REMOTE_ACT] = remote_dma_active_i;
		next_st.status[dcsr_pkg::ST_LOCAL_ACT] = local_dma_active_i;

		// Standby clears flags and the index-pulse count but keeps the sector counters and parameters.
		if (clear_all) begin
			next_st.errors = 8'h00;
			next_st.status[6:0] = dcsr_pkg::RST_STATUS[6:0];
			next_st.idx_count = 2'h0;
			next_st.abort = 1'b0;
		end
		next_st.status[dcsr_pkg::ST_ANY_ERROR] = |next_st.errors;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.status <= dcsr_pkg::RST_STATUS;
			st.header_count_interlock <= dcsr_pkg::RST_HBC;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = ~st.aw_held;
	assign s_axi_wready = ~st.w_held;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign abort_o = st.abort;
	assign command_done_o = st.done;
	// Gates drop on any abort, overrun included, and in standby.
	assign read_gate_out_o = transfer_active_i & ~st.abort &
		~st.errors[dcsr_pkg::ER_OVERRUN] & ~clear_all;
	assign write_gate_out_o = read_gate_out_o;
	assign header_check_sel_o = st.format[dcsr_pkg::FMT_HDR_LO +: 2];
	assign data_check_sel_o = st.format[dcsr_pkg::FMT_DAT_LO +: 2];
	assign ext_header_ecc_o = (header_check_sel_o == dcsr_pkg::CHK_NONE);
	assign sector_subst_o = st.sector;
	assign interlock_strobe_o = st.strobe;
	assign standby_o = clear_all;

endmodule
`default_nettype wire

// ===== verification/dcsr_regs_properties.sv
// Port checker for the status and error register bank.
`default_nettype none
module dcsr_regs_properties (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] header_mode_i,
	input wire logic       header_check_err_i,
	input wire logic       partial_match_i,
	input wire logic       fifo_overflow_i,
	input wire logic       transfer_active_i,
	input wire logic       sector_pulse_i,
	input wire logic       abort_o,
	input wire logic       read_gate_out_o,
	input wire logic [1:0] header_check_sel_o,
	input wire logic       ext_header_ecc_o,
	input wire logic       standby_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_gate_idle: assert property (!transfer_active_i |-> !read_gate_out_o)
		else $error("read gate up without a transfer");
	a_ext_ecc: assert property (ext_header_ecc_o ==
		(header_check_sel_o == 2'h0))
		else $error("external header check flag wrong");
	a_hdr_abort: assert property (header_check_err_i && header_mode_i == 2'h3
		&& !standby_o |-> ##[1:2] abort_o) else $error("no abort on bad header");
	a_partial_abort: assert property (partial_match_i && header_mode_i == 2'h2
		&& !standby_o |-> ##[1:2] abort_o) else $error("no abort on partial match");
	a_fifo_abort: assert property (fifo_overflow_i && !standby_o
		|-> ##[1:2] abort_o) else $error("no abort on fifo loss");
	a_overrun_gate: assert property ($rose(sector_pulse_i) && transfer_active_i
		&& !standby_o |-> ##[1:6] !read_gate_out_o) else $error("gate kept up");
	a_standby_gate: assert property (standby_o |-> !read_gate_out_o)
		else $error("gate up in standby");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped early");
	c_abort: cover property (abort_o);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_standby: cover property (standby_o);
endmodule
bind dcsr_regs dcsr_regs_properties dcsr_regs_properties_inst (.clk_i,
	.rst_n_i, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
	.header_mode_i, .header_check_err_i, .partial_match_i, .fifo_overflow_i,
	.transfer_active_i, .sector_pulse_i, .abort_o, .read_gate_out_o,
	.header_check_sel_o, .ext_header_ecc_o, .standby_o);
`default_nettype wire

// ===== verification/dcsr_disk_model.sv
// Drive-side source of index and sector marks.
`default_nettype none
module dcsr_disk_model (
	input  wire logic clk_i,
	input  wire logic fire_index_i,
	input  wire logic fire_sector_i,
	output logic      index_pulse_o,
	output logic      sector_pulse_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Marks last four cycles so the two-stage synchroniser cannot miss them.
	logic [2:0] idx_cnt = 3'h0;
	logic [2:0] sec_cnt = 3'h0;
	always_ff @(posedge clk_i) begin
		idx_cnt <= fire_index_i ? 3'h4 : idx_cnt - 3'(idx_cnt != 3'h0);
		sec_cnt <= fire_sector_i ? 3'h4 : sec_cnt - 3'(sec_cnt != 3'h0);
	end
	assign index_pulse_o = idx_cnt != 3'h0;
	assign sector_pulse_o = sec_cnt != 3'h0;
endmodule
`default_nettype wire

// ===== verification/dcsr_regs_test.sv
// Self-checking bench for the status and error register bank.
`default_nettype none
module dcsr_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_n_i = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, mode = 2'h2;
	logic [1:0]  header_check_sel_o, data_check_sel_o;
	logic [7:0]  sector_subst_o;
	logic        command_done_o, read_gate_out_o, interlock_strobe_o;
	logic        ext_header_ecc_o, standby_o, idx_p, sec_p, wg;
	// Events: 0 command, 1 header done, 2 header fault, 3 match, 4 partial,
	// 5 data fault, 6 data done, 7 sync lost, 8 overflow, 9 fixup start,
	// 10 fixup end, 11 next header, 12 index mark, 13 sector mark,
	// 14 underrun.
	// Levels: 0 transfer, 1 to 3 dma, 4 located, 5 count zero, 6 sync hunt.
	logic [14:0] ev = 15'h0;
	logic [6:0]  lv = 7'h0;
	logic        done_seen = 1'b0, str_seen = 1'b0;
	int          fail_count = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (command_done_o === 1'b1) done_seen <= 1'b1;
		if (interlock_strobe_o === 1'b1) str_seen <= 1'b1;
	end
	dcsr_disk_model dcsr_disk_model_inst (.clk_i, .fire_index_i(ev[12]),
		.fire_sector_i(ev[13]), .index_pulse_o(idx_p), .sector_pulse_o(sec_p));
	dcsr_regs dcsr_regs_inst (.clk_i, .rst_n_i, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.new_command_i(ev[0]), .header_mode_i(mode), .header_done_i(ev[1]),
		.header_check_err_i(ev[2]), .header_match_i(ev[3]),
		.partial_match_i(ev[4]), .data_check_err_i(ev[5]),
		.data_op_done_i(ev[6]), .transfer_active_i(lv[0]),
		.sync_hunt_i(lv[6]), .sync_lost_i(ev[7]), .fifo_overflow_i(ev[8]),
		.fifo_underrun_i(ev[14]), .local_dma_request_i(lv[1]),
		.remote_dma_active_i(lv[2]), .local_dma_active_i(lv[3]),
		.fixup_start_i(ev[9]), .fixup_end_i(ev[10]),
		.fixup_located_i(lv[4]), .byte_count_zero_i(lv[5]),
		.next_header_i(ev[11]), .fifo_byte_i(8'hA5), .index_pulse_i(idx_p),
		.sector_pulse_i(sec_p), .abort_o(), .command_done_o,
		.read_gate_out_o, .write_gate_out_o(wg), .header_check_sel_o,
		.data_check_sel_o, .sector_subst_o, .interlock_strobe_o,
		.ext_header_ecc_o, .standby_o);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		b = 1'b0;
		s_axi_awaddr <= {a, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge clk_i);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_i);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk_i);
		chk(32'(r), 32'(er));
	endtask
	task automatic rd(input logic [5:0] a);
		logic ar, v;
		v = 1'b0;
		s_axi_araddr <= {a, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v) begin
			@(negedge clk_i);
			ar = s_axi_arready;
			v = s_axi_rvalid;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk_i);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic t_reset;
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv, 32'h02);
		rd(dcsr_pkg::IDX_HBC);
		chk(rv[2:0], 32'h6);
	endtask
	task automatic t_format;
		for (int k = 0; k < 4; k++) begin
			wr(dcsr_pkg::IDX_FORMAT, 8'((3 - k) << 2 | k), dcsr_pkg::RESP_OKAY);
			chk(header_check_sel_o, k);
			chk(data_check_sel_o, 3 - k);
			chk(ext_header_ecc_o, k == 0);
		end
	endtask
	task automatic t_refuse;
		wr(dcsr_pkg::IDX_STATUS, 8'hFF, dcsr_pkg::RESP_SLVERR);
		rd(6'h3F);
		chk(32'(rr), 32'(dcsr_pkg::RESP_SLVERR));
		chk(rv, 32'h0);
		rd(dcsr_pkg::IDX_DIAG);
		chk(rv, 32'hA5);
	endtask
	task automatic t_hdr_fault;
		pulse(0);
		pulse(2);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[2:0], 32'h1);
		pulse(3);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[2:0], 32'h4);
		pulse(6);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[2], 1'b0);
		mode <= 2'h3;
		pulse(2);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h0);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[0], 1'b1);
		pulse(1);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[2], 1'b1);
		mode <= 2'h2;
		pulse(0);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[0], 1'b0);
	endtask
	task automatic t_errors;
		int ek [5] = '{5, 8, 4, 7, 14};
		int eb [5] = '{1, 5, 0, 4, 5};
		for (int i = 0; i < 5; i++) begin
			pulse(0);
			pulse(3);
			pulse(ek[i]);
			pulse(6);
			rd(dcsr_pkg::IDX_ERRORS);
			chk(rv, 32'h1 << eb[i]);
			rd(dcsr_pkg::IDX_STATUS);
			chk(rv[7], 1'b1);
			pulse(0);
			rd(dcsr_pkg::IDX_ERRORS);
			chk(rv, 32'h0);
		end
	endtask
	task automatic t_missing;
		pulse(12);
		repeat (8) @(posedge clk_i);
		pulse(12);
		repeat (8) @(posedge clk_i);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h4);
		pulse(0);
	endtask
	task automatic t_overrun;
		lv[0] <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(read_gate_out_o, 1'b1);
		chk(wg, 1'b1);
		pulse(13);
		repeat (8) @(posedge clk_i);
		chk(read_gate_out_o, 1'b0);
		chk(wg, 1'b0);
		lv[0] <= 1'b0;
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h8);
		pulse(0);
	endtask
	task automatic t_sync;
		lv[6] <= 1'b1;
		pulse(12);
		repeat (8) @(posedge clk_i);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h10);
		lv[6] <= 1'b0;
		pulse(0);
	endtask
	task automatic t_fixup;
		pulse(9);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[6], 1'b1);
		lv[5] <= 1'b1;
		pulse(10);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[6], 1'b0);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h40);
		pulse(0);
	endtask
	task automatic t_mirror;
		lv[3:1] <= 3'h7;
		repeat (3) @(posedge clk_i);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[5:3], 3'h7);
		lv[3:1] <= 3'h0;
		repeat (3) @(posedge clk_i);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv[5:3], 3'h0);
	endtask
	task automatic t_counters;
		wr(dcsr_pkg::IDX_SECTOR, 8'hFE, dcsr_pkg::RESP_OKAY);
		wr(dcsr_pkg::IDX_NSO, 8'h02, dcsr_pkg::RESP_OKAY);
		pulse(1);
		chk(sector_subst_o, 8'hFF);
		rd(dcsr_pkg::IDX_NSO);
		chk(rv, 32'h1);
		chk(done_seen, 1'b0);
		pulse(1);
		chk(sector_subst_o, 8'h00);
		chk(done_seen, 1'b1);
	endtask
	task automatic t_interlock;
		wr(dcsr_pkg::IDX_CONTROL, 8'h02, dcsr_pkg::RESP_OKAY);
		pulse(11);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h80);
		wr(dcsr_pkg::IDX_HBC, 8'h05, dcsr_pkg::RESP_OKAY);
		chk(str_seen, 1'b1);
		rd(dcsr_pkg::IDX_HBC);
		chk(rv[2:0], 32'h5);
		pulse(0);
		pulse(11);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h0);
	endtask
	task automatic t_standby;
		wr(dcsr_pkg::IDX_CONTROL, 8'h01, dcsr_pkg::RESP_OKAY);
		chk(standby_o, 1'b1);
		rd(dcsr_pkg::IDX_STATUS);
		chk(rv, 32'h02);
		rd(dcsr_pkg::IDX_ERRORS);
		chk(rv, 32'h0);
		wr(dcsr_pkg::IDX_CONTROL, 8'h00, dcsr_pkg::RESP_OKAY);
	endtask
	initial begin
		#200us;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_format();
		t_refuse();
		t_hdr_fault();
		t_errors();
		t_missing();
		t_overrun();
		t_sync();
		t_fixup();
		t_mirror();
		t_counters();
		t_interlock();
		t_standby();
		end_of_test();
	end
endmodule
`default_nettype wire
